/* hw/vid_cmd_map.vh */
`ifndef VID_CMD_MAP_VH
`define VID_CMD_MAP_VH

// Bus address byte: 7-bit address plus write bit
`define ADDR_BYTE 8'h68

// Voltage codes
`define VOUT_LAST 7'h4C
`define VOUT_DEFAULT 7'h00

// Over-current limit codes and encodings
`define CODE_OC_FOUR 8'h6F
`define CODE_OC_ONE 8'hF0
`define CODE_OC_TWO 8'h71
`define CODE_OC_THREE 8'h72
`define OC_LEVEL_ONE 2'h0
`define OC_LEVEL_TWO 2'h1
`define OC_LEVEL_THREE 2'h2
`define OC_LEVEL_FOUR 2'h3
`define OC_DEFAULT 2'h1

// Over-temperature codes and encodings
`define CODE_OT_150 8'hF3
`define CODE_OT_130 8'h74
`define CODE_OT_170 8'hF5
`define OT_130 2'h0
`define OT_150 2'h1
`define OT_170 2'h2
`define OT_DEFAULT 2'h1

// Shutdown and start-up
`define CODE_SHUTDOWN 8'hF6
`define CODE_STARTUP 8'h77

// Power-good fault delay codes and encodings
`define CODE_PG_0US 8'h78
`define CODE_PG_10US 8'hF9
`define CODE_PG_20US 8'hFA
`define CODE_PG_40US 8'h7B
`define PG_0US 2'h0
`define PG_10US 2'h1
`define PG_20US 2'h2
`define PG_40US 2'h3
`define PG_DEFAULT 2'h1

// Slew rate: code range, encoding is N minus one
`define SLEW_FIRST 7'h61
`define SLEW_LAST 7'h68
`define SLEW_DEFAULT 3'h0

// Switching frequency codes and encodings
`define CODE_FSW_400 8'hFC
`define CODE_FSW_800 8'h7D
`define CODE_FSW_1200 8'h7E
`define FSW_400 2'h0
`define FSW_800 2'h1
`define FSW_1200 2'h2
`define FSW_DEFAULT 2'h1

// Byte framing
`define BITS_PER_BYTE 4'h8

// Register map
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_VOUT 3'h2
`define REG_PROT 3'h3
`define REG_DYN 3'h4
`define REG_LAST_BYTE 3'h5
`define CTRL_RESET 1'h1
`define STAT_PARITY_BIT 2
`define STAT_CMD_BIT 3

`endif

/* hw/vid_i2c_command_decoder.v */
`timescale 1ns/1ps
`include "vid_cmd_map.vh"

module vid_i2c_command_decoder (
	input wire REF_CLK,
	input wire RESET_N,
	input wire SCL_IN,
	input wire SDA_IN,
	output wire SDA_OUT,
	output wire SDA_OE,
	input wire SOFT_START_DONE,
	output wire [6:0] VOUT_CODE,
	output wire [1:0] OVER_CURRENT_LIMIT,
	output wire [1:0] OVER_TEMP_THRESHOLD,
	output wire SHUTDOWN,
	output wire [1:0] PG_FAULT_DELAY,
	output wire [2:0] SLEW_SEL,
	output wire [1:0] FSW_SEL,
	input wire [2:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output wire [7:0] REG_RDATA
);

	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_ACK_ADDR = 3'h2;
	localparam S_DATA = 3'h3;
	localparam S_ACK_DATA = 3'h4;
	localparam S_IGNORE = 3'h5;

	reg scl_d_r;
	reg sda_d_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [3:0] bit_cnt_r;
	reg [3:0] bit_cnt_nxt;
	reg [7:0] shift_r;
	reg [7:0] shift_nxt;
	reg ack_oe_r;
	reg ack_oe_nxt;
	reg [6:0] vout_r;
	reg [1:0] oc_r;
	reg [1:0] ot_r;
	reg shut_r;
	reg [1:0] pg_r;
	reg [2:0] slew_r;
	reg [1:0] fsw_r;
	reg enable_r;
	reg parity_fail_r;
	reg cmd_seen_r;
	reg [7:0] last_byte_r;
	reg [7:0] rdata_r;
	reg [7:0] rdata_nxt;

	wire start_cond;
	wire stop_cond;
	wire scl_rise;
	wire scl_fall;
	wire byte_full;
	wire parity_ok;
	wire [6:0] code;
	wire is_vout;
	wire is_slew;
	wire data_accept;
	wire [6:0] slew_off;
	wire status_clr_parity;
	wire status_clr_cmd;

	// Pins are already synchronous; one stage of history is enough for edges
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= SCL_IN;
			sda_d_r <= SDA_IN;
		end
	end

	assign start_cond = SCL_IN & scl_d_r & sda_d_r & ~SDA_IN;
	assign stop_cond = SCL_IN & scl_d_r & ~sda_d_r & SDA_IN;
	assign scl_rise = SCL_IN & ~scl_d_r;
	assign scl_fall = ~SCL_IN & scl_d_r;
	assign byte_full = (bit_cnt_r == `BITS_PER_BYTE);

	assign code = shift_r[6:0];
	assign parity_ok = ~(^shift_r);
	assign is_vout = (code <= `VOUT_LAST);
	assign is_slew = (code >= `SLEW_FIRST) && (code <= `SLEW_LAST);
	assign slew_off = code - `SLEW_FIRST;
	// Data byte is decoded on the falling edge that ends its eighth bit
	assign data_accept = (state_r == S_DATA) && scl_fall && byte_full && parity_ok;

	// Bus framing
	always @* begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		ack_oe_nxt = ack_oe_r;
		if (start_cond) begin
			state_nxt = S_ADDR;
			bit_cnt_nxt = 4'h0;
			ack_oe_nxt = 1'b0;
		end else if (stop_cond) begin
			state_nxt = S_IDLE;
			ack_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				S_ADDR, S_DATA: begin
					if (scl_rise && !byte_full) begin
						shift_nxt = {shift_r[6:0], SDA_IN};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && byte_full) begin
						if (state_r == S_ADDR) begin
							if (enable_r && shift_r == `ADDR_BYTE) begin
								state_nxt = S_ACK_ADDR;
								ack_oe_nxt = 1'b1;
							end else begin
								state_nxt = S_IGNORE;
							end
						end else if (parity_ok) begin
							state_nxt = S_ACK_DATA;
							ack_oe_nxt = 1'b1;
						end else begin
							state_nxt = S_IGNORE;
						end
					end
				end
				S_ACK_ADDR, S_ACK_DATA: begin
					// Release on the falling edge that closes the acknowledge bit
					if (scl_fall) begin
						state_nxt = S_DATA;
						bit_cnt_nxt = 4'h0;
						ack_oe_nxt = 1'b0;
					end
				end
				S_IDLE, S_IGNORE: begin
					ack_oe_nxt = 1'b0;
				end
				default: begin
					state_nxt = S_IDLE;
					ack_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			state_r <= S_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ack_oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			ack_oe_r <= ack_oe_nxt;
		end
	end

	// Command execution
	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			vout_r <= `VOUT_DEFAULT;
			oc_r <= `OC_DEFAULT;
			ot_r <= `OT_DEFAULT;
			shut_r <= 1'b0;
			pg_r <= `PG_DEFAULT;
			slew_r <= `SLEW_DEFAULT;
			fsw_r <= `FSW_DEFAULT;
		end else if (data_accept) begin
			if (is_vout) begin
				if (SOFT_START_DONE && !shut_r) begin
					vout_r <= code;
				end
			end else if (is_slew) begin
				slew_r <= slew_off[2:0];
			end else begin
				case (shift_r)
					`CODE_OC_FOUR: oc_r <= `OC_LEVEL_FOUR;
					`CODE_OC_ONE: oc_r <= `OC_LEVEL_ONE;
					`CODE_OC_TWO: oc_r <= `OC_LEVEL_TWO;
					`CODE_OC_THREE: oc_r <= `OC_LEVEL_THREE;
					`CODE_OT_150: ot_r <= `OT_150;
					`CODE_OT_130: ot_r <= `OT_130;
					`CODE_OT_170: ot_r <= `OT_170;
					`CODE_SHUTDOWN: begin
						if (SOFT_START_DONE) begin
							shut_r <= 1'b1;
							vout_r <= `VOUT_DEFAULT;
						end
					end
					`CODE_STARTUP: shut_r <= 1'b0;
					`CODE_PG_0US: pg_r <= `PG_0US;
					`CODE_PG_10US: pg_r <= `PG_10US;
					`CODE_PG_20US: pg_r <= `PG_20US;
					`CODE_PG_40US: pg_r <= `PG_40US;
					`CODE_FSW_400: fsw_r <= `FSW_400;
					`CODE_FSW_800: fsw_r <= `FSW_800;
					`CODE_FSW_1200: fsw_r <= `FSW_1200;
					default: begin
						// Unlisted code: acknowledged, no effect
					end
				endcase
			end
		end
	end

	// Register port: status flags clear on write of one, a new event wins
	assign status_clr_parity = REG_WR && (REG_ADDR == `REG_STATUS) && REG_WDATA[`STAT_PARITY_BIT];
	assign status_clr_cmd = REG_WR && (REG_ADDR == `REG_STATUS) && REG_WDATA[`STAT_CMD_BIT];

	always @(posedge REF_CLK) begin
		if (!RESET_N) begin
			enable_r <= `CTRL_RESET;
			parity_fail_r <= 1'b0;
			cmd_seen_r <= 1'b0;
			last_byte_r <= 8'h00;
			rdata_r <= 8'h00;
		end else begin
			if (REG_WR && REG_ADDR == `REG_CTRL) begin
				enable_r <= REG_WDATA[0];
			end
			if (state_r == S_DATA && scl_fall && byte_full && !parity_ok) begin
				parity_fail_r <= 1'b1;
			end else if (status_clr_parity) begin
				parity_fail_r <= 1'b0;
			end
			if (data_accept) begin
				cmd_seen_r <= 1'b1;
				last_byte_r <= shift_r;
			end else if (status_clr_cmd) begin
				cmd_seen_r <= 1'b0;
			end
			rdata_r <= rdata_nxt;
		end
	end

	// Read data stands only in the cycle after the read strobe
	always @* begin
		rdata_nxt = 8'h00;
		if (REG_RD) begin
			case (REG_ADDR)
				`REG_CTRL: rdata_nxt = {7'h00, enable_r};
				`REG_STATUS: rdata_nxt = {4'h0, cmd_seen_r, parity_fail_r, SOFT_START_DONE, shut_r};
				`REG_VOUT: rdata_nxt = {1'b0, vout_r};
				`REG_PROT: rdata_nxt = {2'h0, pg_r, ot_r, oc_r};
				`REG_DYN: rdata_nxt = {3'h0, fsw_r, slew_r};
				`REG_LAST_BYTE: rdata_nxt = last_byte_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Open drain: the pin is only ever pulled low
	assign SDA_OUT = 1'b0;
	assign SDA_OE = ack_oe_r;
	assign VOUT_CODE = vout_r;
	assign OVER_CURRENT_LIMIT = oc_r;
	assign OVER_TEMP_THRESHOLD = ot_r;
	assign SHUTDOWN = shut_r;
	assign PG_FAULT_DELAY = pg_r;
	assign SLEW_SEL = slew_r;
	assign FSW_SEL = fsw_r;
	assign REG_RDATA = rdata_r;

endmodule // vid_i2c_command_decoder

/* sim/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
	input wire clk,
	input wire sda_oe,
	input wire sda_out,
	output reg scl,
	output wire sda
);
	reg drv_low = 1'b0;
	// Pull-up wire: whoever pulls low wins; clock idles high between frames
	// Device value counts only while its enable is up, so a wrong drive level shows as a lost acknowledge
	assign sda = ~drv_low & ~(sda_oe & ~sda_out);
	initial scl = 1'b1;
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task put(input [7:0] b, output ack);
		integer k;
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				drv_low <= ~b[k];
				tick(1);
				scl <= 1'b1;
				tick(2);
				scl <= 1'b0;
				tick(1);
			end
			drv_low <= 1'b0;
			// Extra low cycle lets the acknowledge settle before the clock rises
			tick(2);
			scl <= 1'b1;
			tick(2);
			ack = ~sda;
			scl <= 1'b0;
			tick(2);
		end
	endtask
	task xfer(input [7:0] a, input [7:0] d, output aa, output da);
		begin
			drv_low <= 1'b0;
			tick(1);
			scl <= 1'b1;
			tick(2);
			drv_low <= 1'b1;
			tick(2);
			scl <= 1'b0;
			tick(1);
			put(a, aa);
			da = 1'b0;
			if (aa) put(d, da);
			drv_low <= 1'b1;
			tick(1);
			scl <= 1'b1;
			tick(2);
			drv_low <= 1'b0;
			tick(2);
		end
	endtask
endmodule // i2c_host_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	reg REF_CLK = 1'b0, RESET_N = 1'b0, SOFT_START_DONE = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
	reg [2:0] REG_ADDR = 3'h0;
	reg [7:0] REG_WDATA = 8'h00;
	wire SCL_IN, SDA_IN, SDA_OUT, SDA_OE, SHUTDOWN;
	wire [6:0] VOUT_CODE;
	wire [1:0] OVER_CURRENT_LIMIT, OVER_TEMP_THRESHOLD, PG_FAULT_DELAY, FSW_SEL;
	wire [2:0] SLEW_SEL;
	wire [7:0] REG_RDATA;
	reg [6:0] e_v = 7'h00;
	reg [1:0] e_oc = 2'h1, e_ot = 2'h1, e_pg = 2'h1, e_fs = 2'h1;
	reg [2:0] e_sl = 3'h0;
	reg e_sd = 1'b0, aa, da;
	integer err_count = 0, tests_run = 0, cyc = 0, i;
	always #5 REF_CLK = ~REF_CLK;
	i2c_host_model u_host (.clk(REF_CLK), .sda_oe(SDA_OE), .sda_out(SDA_OUT), .scl(SCL_IN), .sda(SDA_IN));
	vid_i2c_command_decoder u_dut (.REF_CLK, .RESET_N, .SCL_IN, .SDA_IN, .SDA_OUT, .SDA_OE, .SOFT_START_DONE,
		.VOUT_CODE, .OVER_CURRENT_LIMIT, .OVER_TEMP_THRESHOLD, .SHUTDOWN, .PG_FAULT_DELAY, .SLEW_SEL, .FSW_SEL,
		.REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);
	task close_out;
		begin
			$display("checks %0d errors %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Sweep of both halves takes about 44500 cycles
	always @(posedge REF_CLK) begin
		cyc = cyc + 1;
		if (cyc == 80000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	task chk(input string nm, input [11:0] e, input [11:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("unexpected %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge REF_CLK);
			REG_ADDR <= a;
			REG_WDATA <= d;
			REG_WR <= 1'b1;
			@(posedge REF_CLK);
			REG_WR <= 1'b0;
		end
	endtask
	task rd(input [2:0] a, input [7:0] e);
		begin
			@(posedge REF_CLK);
			REG_ADDR <= a;
			REG_RD <= 1'b1;
			@(posedge REF_CLK);
			REG_RD <= 1'b0;
			#1 chk("rdata", {4'h0, e}, {4'h0, REG_RDATA});
		end
	endtask
	task outs;
		begin
			chk("settings", {e_sd, e_oc, e_ot, e_pg, e_sl, e_fs},
				{SHUTDOWN, OVER_CURRENT_LIMIT, OVER_TEMP_THRESHOLD, PG_FAULT_DELAY, SLEW_SEL, FSW_SEL});
			chk("vout", {5'h0, e_v}, {5'h0, VOUT_CODE});
		end
	endtask
	task cmd(input [7:0] d);
		begin
			u_host.xfer(8'h68, d, aa, da);
			chk("addr ack", 12'h001, {11'h0, aa});
			chk("data ack", {11'h0, ~^d}, {11'h0, da});
			if (~^d) begin
				case (d)
					8'h6F: e_oc = 2'h3;
					8'hF0: e_oc = 2'h0;
					8'h71: e_oc = 2'h1;
					8'h72: e_oc = 2'h2;
					8'hF3: e_ot = 2'h1;
					8'h74: e_ot = 2'h0;
					8'hF5: e_ot = 2'h2;
					8'hF6: if (SOFT_START_DONE) {e_sd, e_v} = 8'h80;
					8'h77: e_sd = 1'b0;
					8'h78: e_pg = 2'h0;
					8'hF9: e_pg = 2'h1;
					8'hFA: e_pg = 2'h2;
					8'h7B: e_pg = 2'h3;
					8'hFC: e_fs = 2'h0;
					8'h7D: e_fs = 2'h1;
					8'h7E: e_fs = 2'h2;
					default: begin
						if (d[6:0] > 7'h60 && d[6:0] < 7'h69) e_sl = d[2:0] - 3'h1;
						else if (d[6:0] < 7'h4D && SOFT_START_DONE && !e_sd) e_v = d[6:0];
					end
				endcase
			end
			outs;
		end
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		@(posedge REF_CLK);
		outs;
		rd(3'h0, 8'h01);
		// Read data must fall back to zero once its cycle has passed
		@(posedge REF_CLK);
		#1 chk("rdata idle", 12'h000, {4'h0, REG_RDATA});
		rd(3'h6, 8'h00);
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h00);
		u_host.xfer(8'hD0, 8'h77, aa, da);
		chk("bad addr", 12'h000, {11'h0, aa});
		u_host.xfer(8'h69, 8'h77, aa, da);
		chk("read addr", 12'h000, {11'h0, aa});
		wr(3'h0, 8'h00);
		u_host.xfer(8'h68, 8'h77, aa, da);
		chk("disabled", 12'h000, {11'h0, aa});
		wr(3'h0, 8'h01);
		// Every byte value, first during soft-start and then after it
		for (i = 0; i < 512; i = i + 1) begin
			SOFT_START_DONE <= (i > 255);
			cmd(i[7:0]);
		end
		rd(3'h1, 8'h0F);
		rd(3'h5, 8'hFF);
		wr(3'h1, 8'h0C);
		rd(3'h1, 8'h03);
		cmd(8'h81);
		cmd(8'h77);
		cmd(8'h81);
		// Reset in mid-run must bring every setting back to its default
		RESET_N <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		e_v = 7'h00;
		e_sd = 1'b0;
		e_oc = 2'h1;
		e_ot = 2'h1;
		e_pg = 2'h1;
		e_sl = 3'h0;
		e_fs = 2'h1;
		@(posedge REF_CLK);
		outs;
		rd(3'h1, 8'h02);
		rd(3'h0, 8'h01);
		cmd(8'h85);
		close_out;
	end
endmodule // tb_top

/* sim/vid_cmd_checker_assertions.sv */
`timescale 1ns/1ps
module vid_cmd_checker (
	input wire REF_CLK,
	input wire RESET_N,
	input wire SCL_IN,
	input wire SDA_OE,
	input wire SOFT_START_DONE,
	input wire [6:0] VOUT_CODE,
	input wire SHUTDOWN,
	input wire [1:0] OVER_CURRENT_LIMIT,
	input wire [1:0] OVER_TEMP_THRESHOLD,
	input wire [1:0] PG_FAULT_DELAY,
	input wire [2:0] SLEW_SEL,
	input wire [1:0] FSW_SEL
);
	wire [10:0] cfg = {OVER_CURRENT_LIMIT, OVER_TEMP_THRESHOLD, PG_FAULT_DELAY, SLEW_SEL, FSW_SEL};
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);
	a_ack_rise_low: assert property ($rose(SDA_OE) |-> !SCL_IN) else $error("ack rise");
	a_ack_fall_low: assert property ($fell(SDA_OE) |-> !SCL_IN) else $error("ack fall");
	// Settings may move only beside an acknowledge, so a rejected byte cannot touch them
	a_cfg_needs_ack: assert property ($changed(cfg) |-> ##[0:1] SDA_OE) else $error("cfg no ack");
	a_vout_needs_ack: assert property ($changed(VOUT_CODE) |-> ##[0:1] SDA_OE) else $error("vout no ack");
	a_sd_needs_ss: assert property ($rose(SHUTDOWN) |-> $past(SOFT_START_DONE)) else $error("sd early");
	a_sd_vout_def: assert property ($rose(SHUTDOWN) |-> VOUT_CODE == 7'h00) else $error("sd vout");
	a_sd_vout_hold: assert property (SHUTDOWN && $past(SHUTDOWN) |-> $stable(VOUT_CODE)) else $error("sd hold");
	a_vout_needs_ss: assert property ($changed(VOUT_CODE) |-> $past(SOFT_START_DONE)) else $error("vout early");
	a_vout_in_range: assert property (VOUT_CODE <= 7'h4C) else $error("vout range");
	c_shutdown: cover property ($rose(SHUTDOWN));
	c_ack: cover property ($rose(SDA_OE));
	c_vout: cover property ($changed(VOUT_CODE));
	c_startup: cover property ($fell(SHUTDOWN));
endmodule // vid_cmd_checker
bind vid_i2c_command_decoder vid_cmd_checker u_chk (.REF_CLK, .RESET_N, .SCL_IN, .SDA_OE, .SOFT_START_DONE,
	.VOUT_CODE, .SHUTDOWN, .OVER_CURRENT_LIMIT, .OVER_TEMP_THRESHOLD, .PG_FAULT_DELAY, .SLEW_SEL, .FSW_SEL);
